// file: hdl/codec_link_pkg.sv
// constants, field layouts and carrier types for the codec register access block
package codec_link_pkg;

  // register byte offsets
  localparam logic [15:0] OFF_COMMAND_PORT = 16'hF708;
  localparam logic [15:0] OFF_STATUS_FLAGS = 16'hF710;
  localparam logic [15:0] OFF_MASKED_FLAGS = 16'hF714;
  localparam logic [15:0] OFF_ENABLE_SET   = 16'hF718;
  localparam logic [15:0] OFF_ENABLE_CLEAR = 16'hF71C;

  // command port fields
  localparam int CMD_READ_BIT = 31;
  localparam int CMD_ID_LSB   = 24;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_DATA_LSB = 0;
  localparam int CODEC_ID_W   = 2;
  localparam int REG_ADDR_W   = 7;
  localparam int REG_DATA_W   = 16;
  localparam logic [REG_ADDR_W-1:0] REG_ADDR_RESET = 7'h00;
  localparam logic [REG_DATA_W-1:0] REG_DATA_RESET = 16'h0000;

  // status flag positions
  localparam int STATUS_W         = 16;
  localparam int ST_MODEM_RX_OVR  = 15;
  localparam int ST_MODEM_TX_UND  = 14;
  localparam int ST_AUDIO_RX_OVR  = 12;
  localparam int ST_LOWFREQ_UND   = 11;
  localparam int ST_CENTER_UND    = 10;
  localparam int ST_SURROUND_UND  = 9;
  localparam int ST_FRONT_UND     = 8;
  localparam int ST_PIN_EVENT     = 5;
  localparam int ST_CMD_READY     = 4;
  localparam int ST_SECONDARY_RDY = 1;
  localparam int ST_PRIMARY_RDY   = 0;
  localparam logic [STATUS_W-1:0] STICKY_MASK  = 16'hDF30;
  localparam logic [STATUS_W-1:0] IMPL_MASK    = 16'hDF33;
  localparam logic [STATUS_W-1:0] STICKY_RESET = 16'h0010;
  localparam logic [STATUS_W-1:0] ENABLE_RESET = 16'h0000;

  // link frame layout, bit positions counted from the first bit of slot 0
  localparam int FRAME_POS_W = 8;
  localparam int SLOT_W      = 20;
  localparam int TX_BITS     = 56;
  localparam logic [FRAME_POS_W-1:0] POS_SLOT0_LAST  = 8'h0F;
  localparam logic [FRAME_POS_W-1:0] POS_SLOT1_LAST  = 8'h23;
  localparam logic [FRAME_POS_W-1:0] POS_SLOT2_LAST  = 8'h37;
  localparam logic [FRAME_POS_W-1:0] POS_SLOT12_LAST = 8'hFF;
  localparam logic [FRAME_POS_W-1:0] POS_FRAME_START = 8'h00;
  localparam int TAG_FRAME_VALID = 15;
  localparam int TAG_SLOT1_VALID = 14;
  localparam int TAG_SLOT2_VALID = 13;
  localparam int TAG_CODEC_READY = 15;
  localparam int SLOT1_READ_BIT  = 19;
  localparam int SLOT1_ADDR_LSB  = 12;
  localparam int SLOT2_DATA_LSB  = 4;

  // build configuration
  localparam logic [CODEC_ID_W-1:0] NUM_CODECS_SERVED = 2'h2;
  localparam logic [2:0] REPLY_TIMEOUT_FRAMES = 3'h4;

  typedef struct packed {
    logic modem_rx_overrun;
    logic modem_tx_underrun;
    logic audio_rx_overrun;
    logic lowfreq_tx_underrun;
    logic center_tx_underrun;
    logic surround_tx_underrun;
    logic front_pair_tx_underrun;
  } dma_events_t;

  typedef struct packed {
    logic                  read_select;
    logic [CODEC_ID_W-1:0] target_codec_select;
    logic [REG_ADDR_W-1:0] codec_reg_address;
    logic [REG_DATA_W-1:0] codec_reg_value;
  } codec_cmd_t;

  typedef enum logic [1:0] {
    CMD_IDLE  = 2'b00,
    CMD_ARM   = 2'b01,
    CMD_SEND  = 2'b11,
    CMD_REPLY = 2'b10
  } cmd_state_t;

endpackage

// file: hdl/codec_reg_access.sv
// codec command port, link status flags and interrupt for an AC-link controller
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

// How it works
// - command bit 31 high asks a codec register read, low asks a write.
// - command bits 25:24 pick the codec the access goes to.
// - ids 0..3 accepted; ids beyond the built codec count finish without link traffic.
// - address field resets to zero, reads back the address of a finished read.
// - data field resets to zero, supplies write data, returns read data.
// - command ready resets to one and shows that a new access may start.
// - a command port write drops command ready until the running access finishes; a write in the cycle after an access finishes leaves it set.
// - writing one to command ready clears it, zero leaves it.
// - modem receive overrun sets sticky bit 15, write one clears.
// - modem transmit underrun sets sticky bit 14, write one clears.
// - audio receive overrun sets sticky bit 12, write one clears.
// - audio transmit underruns set bits 11, 10, 9, 8, each write-one clear.
// - incoming slot 12 bit 0 high sets pin event bit 5.
// - writing one clears pin event only while slot 12 bit 0 is low.
// - bit 1 mirrors the slot 0 ready bit of serial line b.
// - bit 0 mirrors the slot 0 ready bit of serial line a.
// - interrupt is OR of status flags gated by their enable bits.
module codec_reg_access
  import codec_link_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  output logic             O_IRQ,
  input  wire dma_events_t I_DMA_EVENTS,
  input  wire logic        I_BIT_CLK,
  input  wire logic        I_SERIAL_IN_LINE_A,
  input  wire logic        I_SERIAL_IN_LINE_B,
  output logic             O_SYNC,
  output logic             O_SERIAL_OUT
);

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  // out slots 0..2 of one access, first bit on the link at the top
  function automatic logic [TX_BITS-1:0] cmd_frame(input codec_cmd_t c);
    logic [15:0]       tag;
    logic [SLOT_W-1:0] slot1;
    logic [SLOT_W-1:0] slot2;
    tag                                 = 16'h0000;
    tag[TAG_FRAME_VALID]                = 1'b1;
    tag[TAG_SLOT1_VALID]                = 1'b1;
    tag[TAG_SLOT2_VALID]                = ~c.read_select; // a read carries no data slot
    tag[CODEC_ID_W-1:0]                 = c.target_codec_select;
    slot1                               = '0;
    slot1[SLOT1_READ_BIT]               = c.read_select;
    slot1[SLOT1_ADDR_LSB +: REG_ADDR_W] = c.codec_reg_address;
    slot2                               = '0;
    slot2[SLOT2_DATA_LSB +: REG_DATA_W] = c.codec_reg_value;
    cmd_frame                           = {tag, slot1, slot2};
  endfunction

  // pin synchronisers: clock and both data lines pass two flops
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       bclk_prev_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta_reg  <= 3'h0;
      pin_sync_reg  <= 3'h0;
      bclk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg  <= {I_SERIAL_IN_LINE_B, I_SERIAL_IN_LINE_A, I_BIT_CLK};
      pin_sync_reg  <= pin_meta_reg;
      bclk_prev_reg <= pin_sync_reg[0];
    end
  end

  logic       bclk_rise;
  logic       bclk_fall;
  logic [1:0] line_bit;
  assign bclk_rise = pin_sync_reg[0] & ~bclk_prev_reg;
  assign bclk_fall = ~pin_sync_reg[0] & bclk_prev_reg;
  assign line_bit  = pin_sync_reg[2:1];

  // frame position: drive bit pos_reg on a rise, sample it on the next fall
  logic [FRAME_POS_W-1:0] pos_reg;
  logic [FRAME_POS_W-1:0] in_pos;
  assign in_pos = pos_reg - 8'h01;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pos_reg <= POS_FRAME_START;
    end else if (bclk_rise) begin
      pos_reg <= pos_reg + 8'h01;
    end
  end

  // register bus decode
  logic wr_cmd;
  logic wr_status;
  logic wr_en_set;
  logic wr_en_clr;
  assign wr_cmd    = I_WR & hit(I_ADDR, OFF_COMMAND_PORT);
  assign wr_status = I_WR & hit(I_ADDR, OFF_STATUS_FLAGS);
  assign wr_en_set = I_WR & hit(I_ADDR, OFF_ENABLE_SET);
  assign wr_en_clr = I_WR & hit(I_ADDR, OFF_ENABLE_CLEAR);

  // receive side: one shift register per serial input line
  logic [SLOT_W-1:0] rx_shift_reg [2];
  logic [SLOT_W-1:0] rx_slot1_reg [2];
  logic [SLOT_W-1:0] rx_tag_reg   [2];
  logic [1:0]        codec_ready_reg;
  logic [1:0]        pin_level_reg;

  for (genvar ln = 0; ln < 2; ln++) begin : g_rx_line
    logic [SLOT_W-1:0] shifted;
    assign shifted = {rx_shift_reg[ln][SLOT_W-2:0], line_bit[ln]};

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        rx_shift_reg[ln]    <= '0;
        rx_slot1_reg[ln]    <= '0;
        rx_tag_reg[ln]      <= '0;
        codec_ready_reg[ln] <= 1'b0;
        pin_level_reg[ln]   <= 1'b0;
      end else if (bclk_fall) begin
        rx_shift_reg[ln] <= shifted;
        if (in_pos == POS_SLOT0_LAST) begin
          rx_tag_reg[ln]      <= shifted;
          codec_ready_reg[ln] <= shifted[TAG_CODEC_READY];
        end
        if (in_pos == POS_SLOT1_LAST) begin
          rx_slot1_reg[ln] <= shifted;
        end
        if (in_pos == POS_SLOT12_LAST) begin
          pin_level_reg[ln] <= shifted[0];
        end
      end
    end
  end

  // modem codec may sit on either line
  logic pin_level;
  assign pin_level = |pin_level_reg;

  // command port and access sequencer
  codec_cmd_t        cmd_reg;
  cmd_state_t        state_reg;
  logic [TX_BITS-1:0] tx_shift_reg;
  logic [2:0]        frame_wait_reg;
  logic              cmd_done;
  logic              reply_line;
  logic [SLOT_W-1:0] reply_data;
  logic              reply_ok;
  logic              unserved;

  assign unserved   = (I_WDATA[CMD_ID_LSB +: CODEC_ID_W] >= NUM_CODECS_SERVED);
  assign reply_line = cmd_reg.target_codec_select[0];
  assign reply_data = {rx_shift_reg[reply_line][SLOT_W-2:0], line_bit[reply_line]};
  assign reply_ok   = rx_tag_reg[reply_line][TAG_SLOT1_VALID]
                    & rx_tag_reg[reply_line][TAG_SLOT2_VALID];

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cmd_reg.read_select         <= 1'b0;
      cmd_reg.target_codec_select <= '0;
      cmd_reg.codec_reg_address   <= REG_ADDR_RESET;
      cmd_reg.codec_reg_value     <= REG_DATA_RESET;
      state_reg                   <= CMD_IDLE;
      tx_shift_reg                <= '0;
      frame_wait_reg              <= 3'h0;
      cmd_done                    <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      unique case (state_reg)
        CMD_IDLE: begin
          // a write while busy is refused; software must wait for ready
          if (wr_cmd) begin
            cmd_reg.read_select         <= I_WDATA[CMD_READ_BIT];
            cmd_reg.target_codec_select <= I_WDATA[CMD_ID_LSB +: CODEC_ID_W];
            cmd_reg.codec_reg_address   <= I_WDATA[CMD_ADDR_LSB +: REG_ADDR_W];
            cmd_reg.codec_reg_value     <= I_WDATA[CMD_DATA_LSB +: REG_DATA_W];
            if (unserved) begin
              cmd_done <= 1'b1;
            end else begin
              state_reg <= CMD_ARM;
            end
          end
        end
        CMD_ARM: begin
          // load on the last bit of a frame so slot 0 bit 15 leaves on the next rise
          if (bclk_rise && pos_reg == POS_SLOT12_LAST) begin
            tx_shift_reg <= cmd_frame(cmd_reg);
            state_reg    <= CMD_SEND;
          end
        end
        CMD_SEND: begin
          if (bclk_rise) begin
            tx_shift_reg <= {tx_shift_reg[TX_BITS-2:0], 1'b0};
            if (pos_reg == POS_SLOT2_LAST) begin
              frame_wait_reg <= 3'h0;
              if (cmd_reg.read_select) begin
                state_reg <= CMD_REPLY;
              end else begin
                state_reg <= CMD_IDLE;
                cmd_done  <= 1'b1;
              end
            end
          end
        end
        CMD_REPLY: begin
          if (bclk_fall && in_pos == POS_SLOT2_LAST && reply_ok) begin
            cmd_reg.codec_reg_address <=
              rx_slot1_reg[reply_line][SLOT1_ADDR_LSB +: REG_ADDR_W];
            cmd_reg.codec_reg_value   <= reply_data[SLOT2_DATA_LSB +: REG_DATA_W];
            state_reg                 <= CMD_IDLE;
            cmd_done                  <= 1'b1;
          end else if (bclk_rise && pos_reg == POS_SLOT12_LAST) begin
            // a silent codec must not hang the port forever
            if (frame_wait_reg == REPLY_TIMEOUT_FRAMES) begin
              state_reg <= CMD_IDLE;
              cmd_done  <= 1'b1;
            end else begin
              frame_wait_reg <= frame_wait_reg + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // link outputs
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SYNC       <= 1'b0;
      O_SERIAL_OUT <= 1'b0;
    end else if (bclk_rise) begin
      O_SYNC       <= (pos_reg <= POS_SLOT0_LAST);
      O_SERIAL_OUT <= (state_reg == CMD_SEND) & tx_shift_reg[TX_BITS-1];
    end
  end

  // sticky status flags; a set in the clearing cycle wins
  logic [STATUS_W-1:0] sticky_reg;
  logic [STATUS_W-1:0] sticky_set;
  logic [STATUS_W-1:0] sticky_clr;
  logic [STATUS_W-1:0] status_word;
  logic [STATUS_W-1:0] enable_reg;
  logic [STATUS_W-1:0] enable_next;
  logic [STATUS_W-1:0] masked_word;

  always_comb begin
    sticky_set                  = '0;
    sticky_set[ST_MODEM_RX_OVR] = I_DMA_EVENTS.modem_rx_overrun;
    sticky_set[ST_MODEM_TX_UND] = I_DMA_EVENTS.modem_tx_underrun;
    sticky_set[ST_AUDIO_RX_OVR] = I_DMA_EVENTS.audio_rx_overrun;
    sticky_set[ST_LOWFREQ_UND]  = I_DMA_EVENTS.lowfreq_tx_underrun;
    sticky_set[ST_CENTER_UND]   = I_DMA_EVENTS.center_tx_underrun;
    sticky_set[ST_SURROUND_UND] = I_DMA_EVENTS.surround_tx_underrun;
    sticky_set[ST_FRONT_UND]    = I_DMA_EVENTS.front_pair_tx_underrun;
    sticky_set[ST_PIN_EVENT]    = pin_level;
    sticky_set[ST_CMD_READY]    = cmd_done;
    sticky_clr = wr_status ? (I_WDATA[STATUS_W-1:0] & STICKY_MASK) : '0;
    if (pin_level) begin
      sticky_clr[ST_PIN_EVENT] = 1'b0;
    end
    if (wr_cmd) begin
      sticky_clr[ST_CMD_READY] = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sticky_reg <= STICKY_RESET;
    end else begin
      sticky_reg <= ((sticky_reg & ~sticky_clr) | sticky_set) & STICKY_MASK;
    end
  end

  always_comb begin
    status_word                   = sticky_reg;
    status_word[ST_SECONDARY_RDY] = codec_ready_reg[1];
    status_word[ST_PRIMARY_RDY]   = codec_ready_reg[0];
  end

  // interrupt enable, write-one-set and write-one-clear views
  always_comb begin
    enable_next = enable_reg;
    if (wr_en_set) begin
      enable_next = enable_next | I_WDATA[STATUS_W-1:0];
    end
    if (wr_en_clr) begin
      enable_next = enable_next & ~I_WDATA[STATUS_W-1:0];
    end
    enable_next = enable_next & IMPL_MASK;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      enable_reg <= ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  assign masked_word = status_word & enable_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |masked_word;
    end
  end

  // read data valid only in the cycle after the read strobe
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (I_RD) begin
      case (I_ADDR)
        OFF_COMMAND_PORT: begin
          rdata_next = {9'h000, cmd_reg.codec_reg_address, cmd_reg.codec_reg_value};
        end
        OFF_STATUS_FLAGS: begin
          rdata_next = {16'h0000, status_word};
        end
        OFF_MASKED_FLAGS: begin
          rdata_next = {16'h0000, masked_word};
        end
        OFF_ENABLE_SET: begin
          rdata_next = {16'h0000, enable_reg};
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= rdata_next;
    end
  end

endmodule

// file: tb/codec_reg_access_chk.sv
// concurrent checks on the codec register access ports
`timescale 1ns/1ps
module codec_reg_access_chk
  import codec_link_pkg::*;
(
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST_N,
  input wire logic [15:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_IRQ,
  input wire dma_events_t I_DMA_EVENTS,
  input wire logic        I_BIT_CLK,
  input wire logic        I_SERIAL_IN_LINE_A,
  input wire logic        I_SERIAL_IN_LINE_B,
  input wire logic        O_SYNC,
  input wire logic        O_SERIAL_OUT
);
  logic        rd_st;
  logic        wr_st;
  logic        wr_cmd;
  logic [15:0] ev_reg;
  logic [11:0] cnt_reg;
  logic        sync_reg;
  logic        seen_reg;
  assign rd_st  = I_RD && I_ADDR == OFF_STATUS_FLAGS;
  assign wr_st  = I_WR && I_ADDR == OFF_STATUS_FLAGS;
  assign wr_cmd = I_WR && I_ADDR == OFF_COMMAND_PORT;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // events in status layout, one cycle old to meet the following read
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      ev_reg <= 16'h0000;
    else
      ev_reg <= {I_DMA_EVENTS[6:5], 1'b0, I_DMA_EVENTS[4:0], 8'h00};
  end
  // cycles since the last sync rise; the first frame has no reference
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_reg  <= 12'h000;
      sync_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      sync_reg <= O_SYNC;
      cnt_reg  <= (O_SYNC && !sync_reg) ? 12'h001 : cnt_reg + 12'h001;
      if (O_SYNC && !sync_reg)
        seen_reg <= 1'b1;
    end
  end
  cmd_clears_ready_a : assert property (
    wr_cmd && !I_WDATA[25] ##1 rd_st |=> !O_RDATA[ST_CMD_READY])
    else $error("ready still set after command write");
  ready_back_a : assert property (
    wr_cmd && I_WDATA[25] ##1 !I_WR [*2] ##1 rd_st |=> O_RDATA[ST_CMD_READY])
    else $error("ready not back after unserved codec id");
  event_sets_a : assert property (
    ev_reg != 16'h0000 && !$past(I_WR) && rd_st |=> (O_RDATA[15:0] & $past(ev_reg)) == $past(ev_reg))
    else $error("event flag not set");
  w1c_clears_a : assert property (
    wr_st && I_DMA_EVENTS == 7'h00 ##1 rd_st && I_DMA_EVENTS == 7'h00
    |=> (O_RDATA[15:0] & $past(I_WDATA[15:0], 2) & 16'hDF10) == 16'h0000)
    else $error("flag survived write of one");
  sticky_hold_a : assert property (
    rd_st ##1 rd_st |=> (O_RDATA[15:0] & $past(O_RDATA[15:0]) & 16'hDF00)
    == ($past(O_RDATA[15:0]) & 16'hDF00))
    else $error("sticky flag dropped without write");
  irq_match_a : assert property (
    I_RD && I_ADDR == OFF_MASKED_FLAGS |=> O_IRQ == (O_RDATA[15:0] != 16'h0000))
    else $error("interrupt disagrees with masked flags");
  cmd_reserved_a : assert property (
    I_RD && I_ADDR == OFF_COMMAND_PORT |=> O_RDATA[31:23] == 9'h000)
    else $error("command port reserved bits set");
  sync_len_a : assert property (
    !O_SYNC && sync_reg |-> cnt_reg inside {[126:130]})
    else $error("sync not sixteen bits long");
  frame_len_a : assert property (
    O_SYNC && !sync_reg && seen_reg |-> cnt_reg inside {[2046:2050]})
    else $error("frame not 256 bits long");
  cover property (wr_cmd && I_WDATA[CMD_READ_BIT]);
  cover property ($rose(O_IRQ));
  cover property (rd_st ##1 O_RDATA[ST_PIN_EVENT]);
endmodule

bind codec_reg_access codec_reg_access_chk u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .I_DMA_EVENTS(I_DMA_EVENTS),
  .I_BIT_CLK(I_BIT_CLK), .I_SERIAL_IN_LINE_A(I_SERIAL_IN_LINE_A),
  .I_SERIAL_IN_LINE_B(I_SERIAL_IN_LINE_B), .O_SYNC(O_SYNC), .O_SERIAL_OUT(O_SERIAL_OUT)
);

// file: tb/codec_model.sv
// behavioural pair of codecs on the far end of the link
`timescale 1ns/1ps
module codec_model (
  input  wire logic i_sync,
  input  wire logic i_sdo,
  input  wire logic i_rdy_a,
  input  wire logic i_rdy_b,
  input  wire logic i_pin,
  input  wire logic i_mute,
  output logic      o_bclk,
  output logic      o_line_a,
  output logic      o_line_b
);
  logic [15:0]  mem [2][128];
  logic [55:0]  sh;
  logic [255:0] fa, fb, f;
  logic [7:0]   rp, tp;
  logic         sq, pend, pl;
  logic [6:0]   pa;
  logic [15:0]  pd;
  initial begin
    o_bclk = 1'b0;
    o_line_a = 1'b0;
    o_line_b = 1'b0;
    {rp, sq, pend, sh, fa, fb} = '0;
    #7;
    forever #80 o_bclk = ~o_bclk;
  end
  // frame position follows the sync rise seen on the falling bit clock
  always @(negedge o_bclk) begin
    rp = (i_sync && !sq) ? 8'h00 : rp + 8'h01;
    sq = i_sync;
    sh = {sh[54:0], i_sdo};
    if (rp == 8'h37 && sh[55] && sh[54] && !sh[41]) begin
      if (sh[39]) begin
        pend = 1'b1;
        pl = sh[40];
        pa = sh[38:32];
        pd = mem[sh[40]][sh[38:32]];
      end else if (sh[53])
        mem[sh[40]][sh[38:32]] = sh[19:4];
    end
  end
  // reply goes out one frame after the command, on the line of its codec
  always @(posedge o_bclk) begin
    tp = rp + 8'h01;
    if (tp == 8'h00) begin
      fa = '0;
      fb = '0;
      fa[255] = i_rdy_a;
      fb[255] = i_rdy_b;
      fa[0] = i_pin;
      if (pend && !i_mute) begin
        f = {3'b011, 13'h0, 1'b0, pa, 12'h000, pd, 4'h0, 200'h0};
        if (pl)
          fb = fb | f;
        else
          fa = fa | f;
      end
      pend = 1'b0;
    end
    o_line_a = fa[8'hFF - tp];
    o_line_b = fb[8'hFF - tp];
  end
endmodule

// file: tb/tb_codec_reg_access.sv
// self-checking bench for the codec register access block
`timescale 1ns/1ps
`define CHECK(n, e, g) begin comparisons++; if ((e) !== (g)) begin \
  $display("wrong value %s expected %h seen %h", n, e, g); miscompares++; end end
module tb_codec_reg_access
  import codec_link_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rdy_a = 1'b0;
  logic        rdy_b = 1'b0;
  logic        pin = 1'b0;
  logic        mute = 1'b0;
  dma_events_t ev = '0;
  logic [31:0] rdata, d;
  logic        irq, sync, sdo, bclk, line_a, line_b;
  int          miscompares = 0;
  int          comparisons = 0;
  always #10 clk = ~clk;
  codec_reg_access u_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_DMA_EVENTS(ev), .I_BIT_CLK(bclk),
    .I_SERIAL_IN_LINE_A(line_a), .I_SERIAL_IN_LINE_B(line_b), .O_SYNC(sync), .O_SERIAL_OUT(sdo));
  codec_model u_codec (.i_sync(sync), .i_sdo(sdo), .i_rdy_a(rdy_a), .i_rdy_b(rdy_b),
    .i_pin(pin), .i_mute(mute), .o_bclk(bclk), .o_line_a(line_a), .o_line_b(line_b));
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [15:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic st_bit(input int p, input logic e);
    rd_reg(OFF_STATUS_FLAGS);
    `CHECK("status bit", e, d[p])
  endtask
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_ready(input int lim);
    for (int i = 0; i < lim; i++) begin
      rd_reg(OFF_STATUS_FLAGS);
      if (d[ST_CMD_READY] === 1'b1)
        return;
    end
    miscompares++;
    summarize();
  endtask
  // a command may only follow a ready flag
  task automatic access(input logic [31:0] cmd);
    wr_reg(OFF_COMMAND_PORT, cmd);
    st_bit(ST_CMD_READY, 1'b0);
    wait_ready(16000);
  endtask
  task automatic frames(input int n);
    repeat (n * 2048) @(posedge clk);
  endtask
  initial begin
    int p;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(OFF_STATUS_FLAGS);
    `CHECK("status reset", 32'h0000_0010, d)
    rd_reg(OFF_COMMAND_PORT);
    `CHECK("command reset", 32'h0, d)
    rd_reg(16'hF720);
    `CHECK("unmapped read", 32'h0, d)
    `CHECK("irq reset", 1'b0, irq)
    for (int k = 1; k < 4; k++) begin
      rdy_a <= k[0];
      rdy_b <= k[1];
      frames(2);
      rd_reg(OFF_STATUS_FLAGS);
      `CHECK("codec ready", k[1:0], d[1:0])
    end
    for (int k = 0; k < 2; k++)
      access({1'b0, 5'h0, 2'(k), 1'b0, 7'h12, 16'hBEE0 + 16'(k)});
    for (int k = 0; k < 2; k++) begin
      access({1'b1, 5'h0, 2'(k), 1'b0, 7'h12, 16'h0000});
      rd_reg(OFF_COMMAND_PORT);
      `CHECK("read result", {9'h0, 7'h12, 16'hBEE0 + 16'(k)}, d)
    end
    mute <= 1'b1;
    access({1'b1, 5'h0, 2'h0, 1'b0, 7'h33, 16'h0000});
    rd_reg(OFF_COMMAND_PORT);
    `CHECK("fields after timeout", {9'h0, 7'h33, 16'h0000}, d)
    mute <= 1'b0;
    for (int k = 2; k < 4; k++) begin
      wr_reg(OFF_COMMAND_PORT, {1'b0, 5'h0, 2'(k), 1'b0, 7'h44, 16'h1234});
      repeat (2) @(posedge clk);
      st_bit(ST_CMD_READY, 1'b1);
    end
    wr_reg(OFF_STATUS_FLAGS, 32'h0000_FFEF);
    rd_reg(OFF_STATUS_FLAGS);
    `CHECK("ready and codec bits", 3'b111, {d[ST_CMD_READY], d[1:0]})
    wr_reg(OFF_STATUS_FLAGS, 32'h0000_0010);
    st_bit(ST_CMD_READY, 1'b0);
    wr_reg(OFF_COMMAND_PORT, {1'b0, 5'h0, 2'h2, 1'b0, 7'h00, 16'h0000});
    wait_ready(10);
    for (int k = 0; k < 7; k++) begin
      p = k + (k < 5 ? 8 : 9);
      ev <= dma_events_t'(7'h01 << k);
      @(posedge clk);
      ev <= '0;
      st_bit(p, 1'b1);
      wr_reg(OFF_STATUS_FLAGS, 32'h0);
      st_bit(p, 1'b1);
      wr_reg(OFF_STATUS_FLAGS, 32'h1 << p);
      st_bit(p, 1'b0);
    end
    wr_reg(OFF_ENABLE_SET, 32'h0000_8000);
    ev <= dma_events_t'(7'h40);
    @(posedge clk);
    ev <= '0;
    rd_reg(OFF_MASKED_FLAGS);
    `CHECK("masked flags", 32'h0000_8000, d)
    `CHECK("irq raised", 1'b1, irq)
    wr_reg(OFF_ENABLE_CLEAR, 32'h0000_8000);
    rd_reg(OFF_ENABLE_SET);
    `CHECK("irq masked", 2'b00, {irq, d[15]})
    wr_reg(OFF_ENABLE_SET, 32'h0000_8000);
    wr_reg(OFF_STATUS_FLAGS, 32'h0000_8000);
    rd_reg(OFF_MASKED_FLAGS);
    `CHECK("irq cleared", 33'h0, {irq, d})
    pin <= 1'b1;
    frames(2);
    wr_reg(OFF_STATUS_FLAGS, 32'h0000_0020);
    st_bit(ST_PIN_EVENT, 1'b1);
    pin <= 1'b0;
    frames(2);
    st_bit(ST_PIN_EVENT, 1'b1);
    wr_reg(OFF_STATUS_FLAGS, 32'h0000_0020);
    st_bit(ST_PIN_EVENT, 1'b0);
    summarize();
  end
endmodule
